/* File: src/tsr_regs.sv */
// Snapshot, error-inject and Ethernet length register bank
`timescale 1ns/1ps
`default_nettype none
`include "tsr_consts.svh"

module tsr_regs
    import tsr_pkg::*;
(
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    input  wire logic [`TSR_ADDR_W-1:0]       reg_addr,
    input  wire logic [7:0]                   reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [7:0]                   reg_rdata,
    output logic      [`TSR_SNAP_IDX_W-1:0]   snap_src_idx,
    input  wire logic [7:0]                   snap_src_byte,
    output logic      [`TSR_INJ_W-1:0]        inject_pulse,
    output logic      [`TSR_LEN_W-1:0]        eth_idle_nibbles,
    output logic      [`TSR_LEN_W-1:0]        eth_data_nibbles
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [`TSR_INJ_W-1:0]       bit_error_inject_q;
    logic [7:0]                  subchannel_snapshot_request_q;
    logic [`TSR_LEN_HIGH_W-1:0]  eth_idle_len_high_q;
    logic [7:0]                  eth_idle_len_low_q;
    logic [`TSR_LEN_HIGH_W-1:0]  eth_data_len_high_q;
    logic [7:0]                  eth_data_len_low_q;
    logic [7:0]                  rdata_q;
    logic [7:0]                  rdata_d;
    logic [`TSR_SNAP_IDX_W-1:0]  cap_idx_q;
    logic [`TSR_SNAP_IDX_W-1:0]  rd_ofs_q;
    tsr_snap_state_e             state_q;
    logic [7:0]                  snap_mem [0:`TSR_SNAP_DEPTH-1];

    logic wr_inj;
    logic wr_req;
    logic wr_idle_hi;
    logic wr_idle_lo;
    logic wr_data_hi;
    logic wr_data_lo;
    logic rd_snap;
    logic cap_start;
    logic cap_last;

    assign wr_inj     = reg_wr && (reg_addr == `TSR_OFS_ERR_INJECT);
    assign wr_req     = reg_wr && (reg_addr == `TSR_OFS_SNAP_REQ);
    assign wr_idle_hi = reg_wr && (reg_addr == `TSR_OFS_IDLE_HIGH);
    assign wr_idle_lo = reg_wr && (reg_addr == `TSR_OFS_IDLE_LOW);
    assign wr_data_hi = reg_wr && (reg_addr == `TSR_OFS_DATA_HIGH);
    assign wr_data_lo = reg_wr && (reg_addr == `TSR_OFS_DATA_LOW);
    assign rd_snap    = reg_rd && (reg_addr == `TSR_OFS_SNAP_READ);

    assign cap_start = (state_q == TSR_SNAP_IDLE)
                     && subchannel_snapshot_request_q[`TSR_REQ_START_BIT];
    assign cap_last  = (state_q == TSR_SNAP_CAPTURE)
                     && (cap_idx_q == `TSR_SNAP_LAST);

    // ****************************************************************
    // Error injection
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_error_inject_q <= `TSR_INJ_W'(0);
        end else if (wr_inj) begin
            bit_error_inject_q <= reg_wdata[`TSR_INJ_W-1:0];
        end
    end

    tsr_err_inject u_err_inject (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .inject_bits  (bit_error_inject_q),
        .inject_pulse (inject_pulse)
    );

    // ****************************************************************
    // Ethernet message lengths
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            eth_idle_len_high_q <= `TSR_RST_LEN_HIGH;
            eth_idle_len_low_q  <= `TSR_RST_BYTE;
            eth_data_len_high_q <= `TSR_RST_LEN_HIGH;
            eth_data_len_low_q  <= `TSR_RST_BYTE;
        end else begin
            if (wr_idle_hi) begin
                eth_idle_len_high_q <= reg_wdata[`TSR_LEN_HIGH_W-1:0];
            end
            if (wr_idle_lo) begin
                eth_idle_len_low_q <= reg_wdata;
            end
            if (wr_data_hi) begin
                eth_data_len_high_q <= reg_wdata[`TSR_LEN_HIGH_W-1:0];
            end
            if (wr_data_lo) begin
                eth_data_len_low_q <= reg_wdata;
            end
        end
    end

    // Generator sees the pair only as a whole 14-bit count
    assign eth_idle_nibbles = {eth_idle_len_high_q, eth_idle_len_low_q};
    assign eth_data_nibbles = {eth_data_len_high_q, eth_data_len_low_q};

    // ****************************************************************
    // Snapshot request and capture sequencer
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            subchannel_snapshot_request_q <= `TSR_RST_BYTE;
        end else if (wr_req) begin
            // A software write in the finishing cycle is a new request
            subchannel_snapshot_request_q <= reg_wdata;
        end else if (cap_last) begin
            subchannel_snapshot_request_q <= `TSR_RST_BYTE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= TSR_SNAP_IDLE;
            cap_idx_q <= `TSR_SNAP_IDX_W'(0);
        end else begin
            case (state_q)
                TSR_SNAP_IDLE: begin
                    if (cap_start) begin
                        state_q   <= TSR_SNAP_CAPTURE;
                        cap_idx_q <= `TSR_SNAP_IDX_W'(0);
                    end
                end
                TSR_SNAP_CAPTURE: begin
                    cap_idx_q <= cap_idx_q + `TSR_SNAP_IDX_W'(1);
                    if (cap_last) begin
                        state_q <= TSR_SNAP_IDLE;
                    end
                end
                default: begin
                    state_q <= TSR_SNAP_IDLE;
                end
            endcase
        end
    end

    assign snap_src_idx = cap_idx_q;

    // One byte per cycle: all 64 subchannels take 1024 cycles
    always_ff @(posedge core_clk) begin
        if (state_q == TSR_SNAP_CAPTURE) begin
            snap_mem[cap_idx_q] <= snap_src_byte;
        end
    end

    // ****************************************************************
    // Snapshot read offset
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ofs_q <= `TSR_SNAP_IDX_W'(0);
        end else if (cap_start || cap_last) begin
            // Zeroing again at finish undoes reads issued while capturing
            rd_ofs_q <= `TSR_SNAP_IDX_W'(0);
        end else if (rd_snap) begin
            // Wraps after 1024 reads; software tracks its own count
            rd_ofs_q <= rd_ofs_q + `TSR_SNAP_IDX_W'(1);
        end
    end

    // ****************************************************************
    // Read data, one cycle after the strobe
    // ****************************************************************
    always_comb begin
        rdata_d = 8'h00;
        case (reg_addr)
            `TSR_OFS_ERR_INJECT: rdata_d = {4'h0, bit_error_inject_q};
            `TSR_OFS_SNAP_REQ:   rdata_d = subchannel_snapshot_request_q;
            `TSR_OFS_SNAP_READ:  rdata_d = snap_mem[rd_ofs_q];
            `TSR_OFS_IDLE_HIGH:  rdata_d = {2'h0, eth_idle_len_high_q};
            `TSR_OFS_IDLE_LOW:   rdata_d = eth_idle_len_low_q;
            `TSR_OFS_DATA_HIGH:  rdata_d = {2'h0, eth_data_len_high_q};
            `TSR_OFS_DATA_LOW:   rdata_d = eth_data_len_low_q;
            default:             rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_cap_begin;
        cap_start ##1 (state_q == TSR_SNAP_CAPTURE && cap_idx_q == 10'h000);
    endsequence

    sequence s_cap_finish;
        cap_last && !wr_req;
    endsequence

    capture_start_a : assert property (
        cap_start |-> s_cap_begin)
        else $error("Capture did not start from index zero");

    capture_clear_a : assert property (
        s_cap_finish |=> (subchannel_snapshot_request_q == 8'h00)
            && (state_q == TSR_SNAP_IDLE))
        else $error("Request not cleared when capture finished");

    capture_len_a : assert property (
        cap_start ##1 (state_q == TSR_SNAP_CAPTURE)[*8]
            |-> cap_idx_q == 10'h007)
        else $error("Capture index does not step once per cycle");

    first_byte_a : assert property (
        s_cap_finish |=> rd_ofs_q == 10'h000)
        else $error("First read after capture would not return byte zero");

    offset_step_a : assert property (
        rd_snap && !cap_start && !cap_last
            |=> rd_ofs_q == $past(rd_ofs_q) + 10'h001)
        else $error("Read offset did not advance by one");

    offset_reset_a : assert property (
        cap_start |=> rd_ofs_q == 10'h000)
        else $error("Read offset not zeroed at capture start");

    idle_len_a : assert property (
        wr_idle_hi |=> eth_idle_nibbles[13:8] == $past(reg_wdata[5:0]))
        else $error("Idle nibble count high part wrong");

    data_len_a : assert property (
        wr_data_lo |=> eth_data_nibbles[7:0] == $past(reg_wdata))
        else $error("Data nibble count low part wrong");

    read_latency_a : assert property (
        reg_rd && reg_addr == 12'h81b |=> reg_rdata == $past(
            eth_idle_len_low_q))
        else $error("Read data not presented one cycle after strobe");

    snap_read_data_a : assert property (
        rd_snap && state_q == TSR_SNAP_IDLE
            |=> reg_rdata == snap_mem[$past(rd_ofs_q)])
        else $error("Snapshot read returned the wrong captured byte");

    rdata_idle_zero_a : assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("Read data not zero outside a read");

    capture_hold_a : assert property (
        state_q == TSR_SNAP_CAPTURE && !cap_last
            |=> state_q == TSR_SNAP_CAPTURE)
        else $error("Capture ended before the last subchannel byte");

    capture_src_a : assert property (
        state_q == TSR_SNAP_CAPTURE && !cap_last
            |=> snap_src_idx == $past(snap_src_idx) + 10'h001)
        else $error("Source index did not step once per cycle");

    mem_write_a : assert property (
        state_q == TSR_SNAP_CAPTURE
            |=> snap_mem[$past(cap_idx_q)] == $past(snap_src_byte))
        else $error("Captured byte not stored at its index");

    idle_low_a : assert property (
        wr_idle_lo |=> eth_idle_nibbles[7:0] == $past(reg_wdata))
        else $error("Idle nibble count low part wrong");

    data_high_a : assert property (
        wr_data_hi |=> eth_data_nibbles[13:8] == $past(reg_wdata[5:0]))
        else $error("Data nibble count high part wrong");

    inject_reg_a : assert property (
        wr_inj |=> bit_error_inject_q == $past(reg_wdata[3:0]))
        else $error("Inject register write not taken");

endmodule
`default_nettype wire

/* File: src/tsr_consts.svh */
// Offsets, field positions and reset values of the snapshot register bank
// What this block does
// - A rising edge on inject bit 2 injects one Ethernet control bit error.
// - A rising edge on inject bit 3 injects one HDLC control bit error.
// - Rising edges on bits 0 and 1 inject IQ and vendor bit errors.
// - Request bit 0 set starts capture of all 64 subchannels into memory.
// - When capture finishes the request register is cleared to zero, unless software writes it in that same cycle.
// - After the clear, the read-data register presents captured byte 0.
// - Each read of the read-data register steps the byte offset by one, except in a cycle where capture starts or finishes.
// - Idle nibble count is 14 bits: six high bits and eight low bits.
// - Data nibble count is 14 bits: six high bits and eight low bits.
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TSR_ADDR_W            12
`define TSR_OFS_ERR_INJECT    12'h817
`define TSR_OFS_SNAP_REQ      12'h818
`define TSR_OFS_SNAP_READ     12'h819
`define TSR_OFS_IDLE_HIGH     12'h81a
`define TSR_OFS_IDLE_LOW      12'h81b
`define TSR_OFS_DATA_HIGH     12'h81c
`define TSR_OFS_DATA_LOW      12'h81d

// ****************************************************************
// Fields, sizes and reset values
// ****************************************************************
`define TSR_INJ_W             4
`define TSR_INJ_IQ            0
`define TSR_INJ_VENDOR        1
`define TSR_INJ_ETH           2
`define TSR_INJ_HDLC          3
`define TSR_REQ_START_BIT     0
`define TSR_LEN_HIGH_W        6
`define TSR_LEN_W             14
`define TSR_SNAP_IDX_W        10
`define TSR_SNAP_DEPTH        1024
`define TSR_SNAP_LAST         10'h3ff
`define TSR_RST_BYTE          8'h00
`define TSR_RST_LEN_HIGH      6'h00

`endif

/* File: src/tsr_pkg.sv */
// Types shared by the snapshot register bank
package tsr_pkg;

    typedef enum {
        TSR_SNAP_IDLE,
        TSR_SNAP_CAPTURE
    } tsr_snap_state_e;

endpackage

/* File: src/tsr_err_inject.sv */
// Edge detectors turning inject-register bits into one-cycle error pulses
`timescale 1ns/1ps
`default_nettype none
`include "tsr_consts.svh"

module tsr_err_inject
    import tsr_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic [`TSR_INJ_W-1:0]   inject_bits,
    output logic      [`TSR_INJ_W-1:0]   inject_pulse
);

    logic [`TSR_INJ_W-1:0] prev_q;
    logic [`TSR_INJ_W-1:0] pulse_q;

    // ****************************************************************
    // One detector per message type
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < `TSR_INJ_W; i = i + 1) begin : g_bit
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    prev_q[i]  <= 1'b0;
                    pulse_q[i] <= 1'b0;
                end else begin
                    prev_q[i]  <= inject_bits[i];
                    // Only a 0 to 1 change fires; holding the bit high
                    // injects nothing more
                    pulse_q[i] <= inject_bits[i] & ~prev_q[i];
                end
            end
        end
    endgenerate

    assign inject_pulse = pulse_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    inj_eth_edge_a : assert property (
        @(posedge core_clk) disable iff (!rst_n)
        inject_pulse[`TSR_INJ_ETH] == ($past(inject_bits[`TSR_INJ_ETH])
            && !$past(inject_bits[`TSR_INJ_ETH], 2)))
        else $error("Ethernet inject pulse does not follow a rising edge");

    inj_hdlc_edge_a : assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(inject_bits[`TSR_INJ_HDLC]) |=> inject_pulse[`TSR_INJ_HDLC]
            ##1 !inject_pulse[`TSR_INJ_HDLC])
        else $error("HDLC inject pulse missing or longer than one cycle");

    inj_iq_vendor_a : assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (inject_pulse[`TSR_INJ_IQ] |-> $past(inject_bits[`TSR_INJ_IQ]))
        and ($rose(inject_bits[`TSR_INJ_VENDOR])
            |=> inject_pulse[`TSR_INJ_VENDOR]))
        else $error("IQ or vendor inject pulse wrong");

endmodule
`default_nettype wire

/* File: tb/tsr_regs_tb_top.sv */
// Self-checking bench for the snapshot register bank
`timescale 1ns/1ps
`default_nettype none
`include "tsr_consts.svh"

`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module tsr_regs_tb_top import tsr_pkg::*;;

    logic                         core_clk;
    logic                         rst_n;
    logic [`TSR_ADDR_W-1:0]       reg_addr;
    logic [7:0]                   reg_wdata;
    logic                         reg_wr;
    logic                         reg_rd;
    logic [7:0]                   reg_rdata;
    logic [`TSR_SNAP_IDX_W-1:0]   snap_src_idx;
    logic [7:0]                   snap_src_byte;
    logic [7:0]                   salt;
    logic [`TSR_INJ_W-1:0]        inject_pulse;
    logic [`TSR_LEN_W-1:0]        eth_idle_nibbles;
    logic [`TSR_LEN_W-1:0]        eth_data_nibbles;
    logic [7:0]                   rd_val;
    int                           n_mismatch;
    int                           comparisons;
    int                           cycles;
    int                           pulse_cnt [4];

    // ****************************************************************
    // Design and subchannel source
    // ****************************************************************
    tsr_regs i_dut (
        .core_clk         (core_clk),
        .rst_n            (rst_n),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .snap_src_idx     (snap_src_idx),
        .snap_src_byte    (snap_src_byte),
        .inject_pulse     (inject_pulse),
        .eth_idle_nibbles (eth_idle_nibbles),
        .eth_data_nibbles (eth_data_nibbles)
    );

    // Salt lets a second capture be told apart from stale memory
    function automatic logic [7:0] exp_byte(input int i, input logic [7:0] s);
        logic [9:0] ix;
        ix = i[9:0];
        return ix[7:0] ^ {ix[9:8], 6'h2a} ^ s;
    endfunction

    assign snap_src_byte = exp_byte(int'(snap_src_idx), salt);

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Counting high cycles catches both missing and stretched pulses
    always @(posedge core_clk) begin
        cycles++;
        for (int k = 0; k < 4; k++) begin
            if (inject_pulse[k] === 1'b1) pulse_cnt[k]++;
        end
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask

    // Starts a capture and polls until the request register clears
    task automatic capture(input logic [7:0] req);
        int t0;
        int polls;
        t0 = cycles;
        polls = 0;
        wr(12'h818, req);
        rd_chk(12'h818, req);
        rd_val = req;
        while (rd_val !== 8'h00 && polls < 1200) begin
            rd(12'h818, rd_val);
            polls++;
        end
        `CHK(rd_val, 8'h00)
        `CHK((cycles - t0 > 1023) && (cycles - t0 < 1040), 1'b1)
    endtask

    task automatic complete_run();
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        salt = 8'h00;
        n_mismatch = 0;
        comparisons = 0;
        cycles = 0;
        pulse_cnt = '{0, 0, 0, 0};
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int a = 'h817; a <= 'h81d; a++) begin
            // Snapshot memory has no reset value before a first capture
            if (a != 'h819) rd_chk(a[11:0], 8'h00);
        end
        rd_chk(12'h820, 8'h00);
        @(posedge core_clk);
        #1;
        `CHK(reg_rdata, 8'h00)
        wr(12'h81a, 8'hff);
        wr(12'h81b, 8'ha5);
        wr(12'h81c, 8'h12);
        wr(12'h81d, 8'h34);
        wr(12'h820, 8'hff);
        rd_chk(12'h81a, 8'h3f);
        rd_chk(12'h81b, 8'ha5);
        rd_chk(12'h81d, 8'h34);
        @(posedge core_clk);
        #1;
        `CHK(reg_rdata, 8'h00)
        rd_chk(12'h820, 8'h00);
        `CHK(eth_idle_nibbles, 14'h3fa5)
        `CHK(eth_data_nibbles, {6'h12, 8'h34})
        wr(12'h81b, 8'h00);
        #1;
        `CHK(eth_idle_nibbles, 14'h3f00)
        for (int k = 0; k < 4; k++) begin
            wr(12'h817, 8'h01 << k);
            repeat (4) @(posedge core_clk);
            for (int j = 0; j < 4; j++) `CHK(pulse_cnt[j], int'(j <= k))
            wr(12'h817, 8'h01 << k);
            wr(12'h817, 8'h00);
            repeat (4) @(posedge core_clk);
            `CHK(pulse_cnt[k], 1)
        end
        wr(12'h817, 8'hff);
        repeat (4) @(posedge core_clk);
        for (int j = 0; j < 4; j++) `CHK(pulse_cnt[j], 2)
        rd_chk(12'h817, 8'h0f);
        capture(8'h01);
        for (int i = 0; i < 1024; i++) rd_chk(12'h819, exp_byte(i, 8'h00));
        rd_chk(12'h819, exp_byte(0, 8'h00));
        rd_chk(12'h819, exp_byte(1, 8'h00));
        wr(12'h819, 8'h55);
        rd_chk(12'h819, exp_byte(2, 8'h00));
        @(posedge core_clk);
        salt <= 8'h5a;
        capture(8'hff);
        rd_chk(12'h819, exp_byte(0, 8'h5a));
        rd_chk(12'h819, exp_byte(1, 8'h5a));
        complete_run();
    end

endmodule

`default_nettype wire
